// ==== hdl/wdr_regs.svh ====
`ifndef WDR_REGS_SVH
`define WDR_REGS_SVH
// Register byte offsets
`define WDR_ADR_W 8
`define WDR_OFF_CTRL 8'h00
`define WDR_OFF_START 8'h04
`define WDR_OFF_PERIOD 8'h08
`define WDR_OFF_HOLD 8'h0C
`define WDR_OFF_DELAY 8'h10
`define WDR_OFF_PULSE 8'h14
`define WDR_OFF_RAILSEL 8'h18
`define WDR_OFF_GPISEL 8'h1C
`define WDR_OFF_PINSEL 8'h20
`define WDR_OFF_CMD 8'h24
`define WDR_OFF_STATUS 8'h28
// Control bits
`define WDR_CTRL_WD_EN 0
`define WDR_CTRL_MERGE 1
`define WDR_CTRL_RST_EN 2
`define WDR_CTRL_RST_PULSE 3
`define WDR_CTRL_EXP_PULSE 4
// Pin select fields: 5-bit pin index plus an enable bit
`define WDR_PIN_KICK 0
`define WDR_PIN_KICK_EN 5
`define WDR_PIN_EXP 8
`define WDR_PIN_EXP_EN 13
`define WDR_PIN_RST 16
`define WDR_PIN_RST_EN 21
`define WDR_PIN_CLR 24
`define WDR_PIN_CLR_EN 29
`define WDR_PINSEL_MASK 32'h3F3F3F3F
// Command bits
`define WDR_CMD_KICK 0
`define WDR_CMD_CLEAR 1
// Status bits
`define WDR_ST_EXPIRED 0
`define WDR_ST_LATCHED 1
`define WDR_ST_RST 2
`define WDR_ST_COND 3
`define WDR_ST_WD 4
// Reset values
`define WDR_CTRL_RST 5'h04
`define WDR_START_RST 18'h003E8
`define WDR_PERIOD_RST 18'h003E8
`define WDR_HOLD_RST 4'h0
`define WDR_DELAY_RST 5'h00
`define WDR_PULSE_RST 15'h0001
`define WDR_PINSEL_RST 32'h00200000
`define WDR_RST_PIN_RST 0
// Timing
`define WDR_CLK_KHZ 250000
`define WDR_TICK_MS 1
`define WDR_MS_CYCLES (`WDR_CLK_KHZ * `WDR_TICK_MS)
`define WDR_TMR_W 21
`define WDR_WD_MIN_MS 18'h00001
`define WDR_WD_MAX_MS 18'h3F000
`define WDR_PW_MIN_MS 15'h0001
`define WDR_PW_MAX_MS 15'h7E00
`define WDR_HOLD_BASE_MS 21'h000064
`define WDR_DLY_MAX_SEL 5'h10
`define WDR_EXP_PULSE_MS 21'h000001
`endif

// ==== hdl/wdr_pkg.sv ====
`default_nettype none
package wdr_pkg;
  typedef enum logic [4:0] {
    WD_OFF = 5'h01,
    WD_HOLD = 5'h02,
    WD_START = 5'h04,
    WD_RUN = 5'h08,
    WD_EXP = 5'h10
  } wdr_wd_state_type;
  typedef enum logic [4:0] {
    RS_ASSERT = 5'h01,
    RS_DELAY = 5'h02,
    RS_RELEASED = 5'h04,
    RS_PULSE = 5'h08,
    RS_REARM = 5'h10
  } wdr_rs_state_type;
endpackage : wdr_pkg
`default_nettype wire

// ==== hdl/wdr_tmr_if.sv ====
`include "wdr_regs.svh"
`default_nettype none
interface wdr_tmr_if;
  logic load;
  logic [`WDR_TMR_W-1:0] value;
  logic busy;
  logic done;
  modport ctl (output load, output value, input busy, input done);
  modport tmr (input load, input value, output busy, output done);
endinterface : wdr_tmr_if
`default_nettype wire

// ==== hdl/wdr_ms_timer.sv ====
`include "wdr_regs.svh"
`default_nettype none
module wdr_ms_timer #(
  parameter int unsigned MS_CYCLES = `WDR_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  wdr_tmr_if.tmr t
);
  localparam int SW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  logic [SW-1:0] sub_reg;
  logic [`WDR_TMR_W-1:0] ms_reg;
  logic run_reg;
  logic done_reg;
  logic sub_wrap;
  logic last_ms;

  assign sub_wrap = (sub_reg == SW'(MS_CYCLES - 1));
  assign last_ms = (ms_reg == `WDR_TMR_W'(1));
  assign t.busy = run_reg;
  assign t.done = done_reg;

  // Prescaler restarts on load so every period is exact
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sub_reg <= '0;
    end else if (t.load || sub_wrap) begin
      sub_reg <= '0;
    end else if (run_reg) begin
      sub_reg <= sub_reg + 1'b1;
    end
  end

  // Millisecond countdown
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ms_reg <= '0;
      run_reg <= 1'b0;
    end else if (t.load) begin
      ms_reg <= t.value;
      run_reg <= (t.value != '0);
    end else if (run_reg && sub_wrap) begin
      ms_reg <= ms_reg - 1'b1;
      run_reg <= !last_ms;
    end
  end

  // One-cycle done; a zero load finishes at once
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= t.load ? (t.value == '0) : (run_reg && sub_wrap && last_ms);
    end
  end
endmodule : wdr_ms_timer
`default_nettype wire

// ==== hdl/wdr_kick_sync.sv ====
`default_nettype none
module wdr_kick_sync (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pin_level,
  output logic level,
  output logic toggle
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Two-flop synchroniser, third flop for edge detection
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_level;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Either edge counts as a toggle
  assign level = sync_reg;
  assign toggle = sync_reg ^ last_reg;
endmodule : wdr_kick_sync
`default_nettype wire

// ==== hdl/wdr_watchdog_reset.sv ====
`include "wdr_regs.svh"
`default_nettype none
// How it works
// - Every kick input toggle after the hold-off restarts the supervision timer.
// - Missing kicks let the timer expire and raise the expiry output.
// - A bus kick command acts exactly like a kick input toggle.
// - Kick input and expiry output are assignable to any general pin.
// - Expiry goes to the logic output path or merges into system reset.
// - Timer period spans 1 ms to 258.048 s.
// - After expiry, a kick toggle or kick command restarts counting.
// - Optional initial hold-off: zero, or 100 ms doubling up to 1638.4 s.
// - Separate start time before first kick and reset time between kicks.
// - System reset drives an assignable general pin.
// - Reset releases only with selected rails and inputs good, after delay.
// - Release delay: zero, or 1 ms doubling up to about 32.8 s.
// - Level mode reasserts at once on any selected rail or input loss.
// - Pulse mode gives one reset pulse when power good is reached.
// - Pulse width spans 1 ms to 32.256 s.
// - Merged expiry toggles reset using pulse-width or input-tracking release.
// - System reset is asserted out of reset.
// - Reconfiguring reset briefly asserts it while conditions are rechecked.
// - Expiry status plus latched copy, cleared by command or chosen pin.
module wdr_watchdog_reset
  import wdr_pkg::*;
#(
  parameter int unsigned N_RAIL = 24,
  parameter int unsigned N_GPIO = 24,
  parameter int unsigned MS_CYCLES = `WDR_MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`WDR_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_GPIO-1:0] gpio_in,
  output logic [N_GPIO-1:0] gpio_out,
  output logic [N_GPIO-1:0] gpio_oe,
  input wire logic [N_RAIL-1:0] rail_pg_on,
  input wire logic [N_RAIL-1:0] rail_pg_bad,
  output logic expiry_to_logic,
  output logic expiry_latch_to_logic
);
  logic [4:0] ctrl_reg;
  logic [17:0] start_reg;
  logic [17:0] period_reg;
  logic [3:0] hold_reg;
  logic [4:0] dly_reg;
  logic [14:0] pw_reg;
  logic [N_RAIL-1:0] rail_sel_reg;
  logic [N_GPIO-1:0] gpi_sel_reg;
  logic [31:0] pinsel_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  logic [8:0] status_vec;
  logic access, wr_take, reconfig, kick_cmd, clr_cmd;
  logic wd_en, merge, rst_en, pulse_mode, exp_pulse;
  logic [4:0] kick_pin, exp_pin, rst_pin, clr_pin;
  logic kick_en, exp_en, rst_pin_en, clr_en;
  logic kick_raw, clr_raw, kick_tog, clr_lvl, clr_hit, kick_evt;
  logic cond_good, cond_bad, rst_asserted, expired, wd_expire, exp_out;
  logic lat_reg;
  logic [N_GPIO-1:0] gpio_out_reg, gpio_oe_reg;
  wdr_wd_state_type wd_reg, wd_next;
  wdr_rs_state_type rs_reg, rs_next;

  wdr_tmr_if wdt ();
  wdr_tmr_if rst_t ();

  // Merge write data into a register by byte lane
  function automatic logic [31:0] bmerge(input logic [31:0] old_val);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (wb_sel_i[b]) begin
        res[b*8 +: 8] = wb_dat_i[b*8 +: 8];
      end
    end
    return res;
  endfunction : bmerge

  // Hold-off select to milliseconds
  function automatic logic [`WDR_TMR_W-1:0] hold_ms(input logic [3:0] sel);
    if (sel == 4'h0) begin
      return '0;
    end
    return `WDR_HOLD_BASE_MS << (sel - 4'h1);
  endfunction : hold_ms

  // Release delay select to milliseconds
  function automatic logic [`WDR_TMR_W-1:0] dly_ms(input logic [4:0] sel);
    logic [4:0] s;
    s = (sel > `WDR_DLY_MAX_SEL) ? `WDR_DLY_MAX_SEL : sel;
    if (s == 5'h00) begin
      return '0;
    end
    return `WDR_TMR_W'(1) << (s - 5'h01);
  endfunction : dly_ms

  // Watchdog time clamped to its legal span
  function automatic logic [`WDR_TMR_W-1:0] wd_ms(input logic [17:0] v);
    logic [17:0] c;
    c = (v < `WDR_WD_MIN_MS) ? `WDR_WD_MIN_MS : (v > `WDR_WD_MAX_MS) ? `WDR_WD_MAX_MS : v;
    return `WDR_TMR_W'(c);
  endfunction : wd_ms

  // Pulse width clamped to its legal span
  function automatic logic [`WDR_TMR_W-1:0] pw_ms(input logic [14:0] v);
    logic [14:0] c;
    c = (v < `WDR_PW_MIN_MS) ? `WDR_PW_MIN_MS : (v > `WDR_PW_MAX_MS) ? `WDR_PW_MAX_MS : v;
    return `WDR_TMR_W'(c);
  endfunction : pw_ms

  // Field decode
  assign wd_en = ctrl_reg[`WDR_CTRL_WD_EN];
  assign merge = ctrl_reg[`WDR_CTRL_MERGE];
  assign rst_en = ctrl_reg[`WDR_CTRL_RST_EN];
  assign pulse_mode = ctrl_reg[`WDR_CTRL_RST_PULSE];
  assign exp_pulse = ctrl_reg[`WDR_CTRL_EXP_PULSE];
  assign kick_pin = pinsel_reg[`WDR_PIN_KICK +: 5];
  assign kick_en = pinsel_reg[`WDR_PIN_KICK_EN];
  assign exp_pin = pinsel_reg[`WDR_PIN_EXP +: 5];
  assign exp_en = pinsel_reg[`WDR_PIN_EXP_EN];
  assign rst_pin = pinsel_reg[`WDR_PIN_RST +: 5];
  assign rst_pin_en = pinsel_reg[`WDR_PIN_RST_EN];
  assign clr_pin = pinsel_reg[`WDR_PIN_CLR +: 5];
  assign clr_en = pinsel_reg[`WDR_PIN_CLR_EN];

  // Bus strobes; writes and commands act at the edge where ack is high
  assign access = wb_cyc_i && wb_stb_i;
  assign wr_take = access && wb_we_i && ack_reg;
  assign kick_cmd = wr_take && (wb_adr_i == `WDR_OFF_CMD) && wb_sel_i[0] && wb_dat_i[`WDR_CMD_KICK];
  assign clr_cmd = wr_take && (wb_adr_i == `WDR_OFF_CMD) && wb_sel_i[0] && wb_dat_i[`WDR_CMD_CLEAR];
  assign reconfig = wr_take && ((wb_adr_i == `WDR_OFF_CTRL) || (wb_adr_i == `WDR_OFF_DELAY) ||
                    (wb_adr_i == `WDR_OFF_PULSE) || (wb_adr_i == `WDR_OFF_RAILSEL) ||
                    (wb_adr_i == `WDR_OFF_GPISEL) || (wb_adr_i == `WDR_OFF_PINSEL));
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Register writes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_reg <= `WDR_CTRL_RST;
      start_reg <= `WDR_START_RST;
      period_reg <= `WDR_PERIOD_RST;
      hold_reg <= `WDR_HOLD_RST;
      dly_reg <= `WDR_DELAY_RST;
      pw_reg <= `WDR_PULSE_RST;
      rail_sel_reg <= '0;
      gpi_sel_reg <= '0;
      pinsel_reg <= `WDR_PINSEL_RST;
    end else if (wr_take) begin
      case (wb_adr_i)
        `WDR_OFF_CTRL: ctrl_reg <= 5'(bmerge(32'(ctrl_reg)));
        `WDR_OFF_START: start_reg <= 18'(bmerge(32'(start_reg)));
        `WDR_OFF_PERIOD: period_reg <= 18'(bmerge(32'(period_reg)));
        `WDR_OFF_HOLD: hold_reg <= 4'(bmerge(32'(hold_reg)));
        `WDR_OFF_DELAY: dly_reg <= 5'(bmerge(32'(dly_reg)));
        `WDR_OFF_PULSE: pw_reg <= 15'(bmerge(32'(pw_reg)));
        `WDR_OFF_RAILSEL: rail_sel_reg <= N_RAIL'(bmerge(32'(rail_sel_reg)));
        `WDR_OFF_GPISEL: gpi_sel_reg <= N_GPIO'(bmerge(32'(gpi_sel_reg)));
        `WDR_OFF_PINSEL: pinsel_reg <= bmerge(pinsel_reg) & `WDR_PINSEL_MASK;
        default: ;
      endcase
    end
  end

  // Status word
  always_comb begin
    status_vec = '0;
    status_vec[`WDR_ST_EXPIRED] = expired;
    status_vec[`WDR_ST_LATCHED] = lat_reg;
    status_vec[`WDR_ST_RST] = rst_asserted;
    status_vec[`WDR_ST_COND] = cond_good;
    status_vec[`WDR_ST_WD +: 5] = wd_reg;
  end

  // Read mux; unmapped offsets and the command word read zero
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      `WDR_OFF_CTRL: rd_data = 32'(ctrl_reg);
      `WDR_OFF_START: rd_data = 32'(start_reg);
      `WDR_OFF_PERIOD: rd_data = 32'(period_reg);
      `WDR_OFF_HOLD: rd_data = 32'(hold_reg);
      `WDR_OFF_DELAY: rd_data = 32'(dly_reg);
      `WDR_OFF_PULSE: rd_data = 32'(pw_reg);
      `WDR_OFF_RAILSEL: rd_data = 32'(rail_sel_reg);
      `WDR_OFF_GPISEL: rd_data = 32'(gpi_sel_reg);
      `WDR_OFF_PINSEL: rd_data = pinsel_reg;
      `WDR_OFF_STATUS: rd_data = 32'(status_vec);
      default: rd_data = '0;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= access && !ack_reg;
      if (access && !ack_reg && !wb_we_i) begin
        dat_reg <= rd_data;
      end
    end
  end

  // Kick and clear pins picked from the general inputs
  assign kick_raw = (32'(kick_pin) < N_GPIO) ? gpio_in[kick_pin] : 1'b0;
  assign clr_raw = (32'(clr_pin) < N_GPIO) ? gpio_in[clr_pin] : 1'b0;

  wdr_kick_sync u_kick_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_level(kick_raw),
    .level(),
    .toggle(kick_tog)
  );

  wdr_kick_sync u_clr_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_level(clr_raw),
    .level(clr_lvl),
    .toggle()
  );

  assign clr_hit = clr_en && clr_lvl;
  assign kick_evt = (kick_en && kick_tog) || kick_cmd;

  wdr_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_wd_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .t(wdt.tmr)
  );

  wdr_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_rst_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .t(rst_t.tmr)
  );

  // Supervision timer sequencing
  always_comb begin
    wd_next = wd_reg;
    wdt.load = 1'b0;
    wdt.value = '0;
    case (wd_reg)
      WD_OFF: begin
        wd_next = WD_HOLD;
        wdt.load = 1'b1;
        wdt.value = hold_ms(hold_reg);
      end
      WD_HOLD: begin
        if (wdt.done) begin
          wd_next = WD_START;
          wdt.load = 1'b1;
          wdt.value = wd_ms(start_reg);
        end
      end
      WD_START, WD_RUN: begin
        if (kick_evt) begin
          wd_next = WD_RUN;
          wdt.load = 1'b1;
          wdt.value = wd_ms(period_reg);
        end else if (wdt.done) begin
          wd_next = WD_EXP;
          wdt.load = 1'b1;
          wdt.value = `WDR_EXP_PULSE_MS;
        end
      end
      WD_EXP: begin
        if (kick_evt) begin
          wd_next = WD_RUN;
          wdt.load = 1'b1;
          wdt.value = wd_ms(period_reg);
        end
      end
      default: wd_next = WD_OFF;
    endcase
    if (!wd_en) begin
      wd_next = WD_OFF;
      wdt.load = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wd_reg <= WD_OFF;
    end else begin
      wd_reg <= wd_next;
    end
  end

  assign expired = (wd_reg == WD_EXP);
  assign wd_expire = wd_en && !kick_evt && wdt.done && ((wd_reg == WD_START) || (wd_reg == WD_RUN));
  assign exp_out = exp_pulse ? (expired && wdt.busy) : expired;
  assign expiry_to_logic = expired;
  assign expiry_latch_to_logic = lat_reg;

  // Latched expiry; a new expiry wins over a clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lat_reg <= 1'b0;
    end else if (wd_expire) begin
      lat_reg <= 1'b1;
    end else if (clr_cmd || clr_hit) begin
      lat_reg <= 1'b0;
    end
  end

  // Release and loss conditions over the selected rails and inputs
  assign cond_good = (&(rail_pg_on | ~rail_sel_reg)) && (&(gpio_in | ~gpi_sel_reg));
  assign cond_bad = (|(rail_pg_bad & rail_sel_reg)) || (|(~gpio_in & gpi_sel_reg));

  // System reset sequencing
  always_comb begin
    rs_next = rs_reg;
    rst_t.load = 1'b0;
    rst_t.value = '0;
    case (rs_reg)
      RS_ASSERT: begin
        if (cond_good) begin
          rs_next = RS_DELAY;
          rst_t.load = 1'b1;
          rst_t.value = dly_ms(dly_reg);
        end
      end
      RS_DELAY: begin
        if (!cond_good) begin
          rs_next = RS_ASSERT;
        end else if (rst_t.done) begin
          rs_next = RS_RELEASED;
        end
      end
      RS_RELEASED: begin
        if (merge && wd_expire) begin
          rs_next = pulse_mode ? RS_PULSE : RS_ASSERT;
          rst_t.load = pulse_mode;
          rst_t.value = pw_ms(pw_reg);
        end else if (cond_bad) begin
          rs_next = pulse_mode ? RS_REARM : RS_ASSERT;
        end
      end
      RS_REARM: begin
        if (cond_good) begin
          rs_next = RS_PULSE;
          rst_t.load = 1'b1;
          rst_t.value = pw_ms(pw_reg);
        end
      end
      RS_PULSE: begin
        if (rst_t.done) begin
          rs_next = RS_RELEASED;
        end
      end
      default: rs_next = RS_ASSERT;
    endcase
    if (reconfig || !rst_en) begin
      rs_next = RS_ASSERT;
      rst_t.load = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rs_reg <= RS_ASSERT;
    end else begin
      rs_reg <= rs_next;
    end
  end

  assign rst_asserted = (rs_reg != RS_RELEASED) && (rs_reg != RS_REARM);

  // Pin drivers; the reset pin wins over the expiry pin on a clash
  for (genvar i = 0; i < N_GPIO; i++) begin : g_pin
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        gpio_oe_reg[i] <= (i == `WDR_RST_PIN_RST);
        gpio_out_reg[i] <= 1'b0;
      end else if (rst_pin_en && (rst_pin == 5'(i))) begin
        gpio_oe_reg[i] <= 1'b1;
        gpio_out_reg[i] <= !rst_asserted;
      end else if (exp_en && (exp_pin == 5'(i))) begin
        gpio_oe_reg[i] <= 1'b1;
        gpio_out_reg[i] <= exp_out;
      end else begin
        gpio_oe_reg[i] <= 1'b0;
        gpio_out_reg[i] <= 1'b0;
      end
    end
  end

  assign gpio_out = gpio_out_reg;
  assign gpio_oe = gpio_oe_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  kick_pin_restart_a: assert property (
    (kick_en && kick_tog && wd_en && wd_reg == WD_RUN) |=> (wd_reg == WD_RUN && wdt.busy))
    else $error("kick toggle did not restart timer");
  expiry_raise_a: assert property (
    wd_expire |=> (expired && lat_reg && expiry_to_logic))
    else $error("expiry not raised");
  cmd_kick_a: assert property (
    (kick_cmd && wd_en && wd_reg == WD_START) |=> (wd_reg == WD_RUN))
    else $error("bus kick ignored");
  expiry_restart_a: assert property (
    (kick_evt && wd_en && expired) |=> (wd_reg == WD_RUN && !expired))
    else $error("no restart after expiry");
  hold_quiet_a: assert property (
    (wd_reg == WD_HOLD && !wdt.done) |=> (wd_reg == WD_HOLD || wd_reg == WD_OFF))
    else $error("timer left hold-off early");
  latch_sticky_a: assert property (
    (lat_reg && !clr_cmd && !clr_hit) |=> lat_reg)
    else $error("latched expiry lost");
  rst_default_a: assert property (
    !$past(nrst) |-> rst_asserted [*2])
    else $error("reset not asserted after reset");
  reconf_assert_a: assert property (
    reconfig |=> rst_asserted [*2])
    else $error("reconfig did not assert reset");
  level_drop_a: assert property (
    (rs_reg == RS_RELEASED && !pulse_mode && cond_bad && rst_en && !reconfig) |=> rst_asserted)
    else $error("level loss did not assert reset");
  release_cond_a: assert property (
    ($fell(rst_asserted) && $past(rs_reg) == RS_DELAY) |-> $past(cond_good))
    else $error("released without conditions");
  merge_toggle_a: assert property (
    (rs_reg == RS_RELEASED && merge && wd_expire && rst_en && !reconfig) |=> rst_asserted)
    else $error("merged expiry did not toggle reset");

  expiry_seen_c: cover property (wd_expire);
  release_seen_c: cover property (rs_reg == RS_DELAY ##1 rs_reg == RS_RELEASED);
  pulse_seen_c: cover property (rs_reg == RS_PULSE ##1 rs_reg == RS_RELEASED);
  cmd_kick_c: cover property (kick_cmd && wd_reg == WD_RUN);
endmodule : wdr_watchdog_reset
`default_nettype wire

// ==== sim/wdr_host_model.sv ====
`default_nettype none
module wdr_host_model (
  input wire logic ref_clk,
  input wire logic sys_rst_n,
  input wire logic kick_go,
  output logic kick_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_reg = 1'b0;
  // Host flips the kick line on request; a host held in reset cannot kick
  always @(posedge ref_clk) begin
    if (kick_go && sys_rst_n) begin
      tog_reg <= ~tog_reg;
    end
  end
  assign kick_pin = tog_reg;
endmodule : wdr_host_model
`default_nettype wire

// ==== sim/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, cyc, stb, we, kick_go;
  logic [7:0] adr;
  logic [31:0] dat, q;
  logic [23:0] gin, pg_on, pg_bad;
  wire logic [31:0] wb_q;
  wire logic ack, kick_pin, exp_l, lat_l;
  wire logic [23:0] gout, goe, gpio_in;
  int failures, n_tests, n;
  assign gpio_in = {gin[23:2], kick_pin, gin[0]};
  wdr_watchdog_reset #(.MS_CYCLES(4)) dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_q), .wb_ack_o(ack),
    .gpio_in(gpio_in), .gpio_out(gout), .gpio_oe(goe), .rail_pg_on(pg_on), .rail_pg_bad(pg_bad),
    .expiry_to_logic(exp_l), .expiry_latch_to_logic(lat_l));
  wdr_host_model host (.ref_clk(ref_clk), .sys_rst_n(gout[0]), .kick_go(kick_go), .kick_pin(kick_pin));
  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : wt
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = wb_q;
    chk("ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  // Cycles until pin p of gout reaches level v
  task automatic wait_pin(input int p, input logic v);
    n = 0;
    while (gout[p] !== v && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_pin
  task automatic kick();
    kick_go <= 1'b1;
    @(posedge ref_clk);
    kick_go <= 1'b0;
  endtask : kick
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic t_regs();
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h14, 8'h20, 8'h24, 8'h40};
    logic [31:0] rv [6] = '{32'h4, 32'h3E8, 32'h1, 32'h00200000, 32'h0, 32'h0};
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ra[i], 32'h0);
      chk("reg", q, rv[i]);
    end
  endtask : t_regs
  task automatic t_wdog();
    wb(1'b1, 8'h20, 32'h00202221);
    wb(1'b1, 8'h04, 32'h5);
    wb(1'b1, 8'h08, 32'h3);
    wb(1'b1, 8'h00, 32'h5);
    wait_pin(2, 1'b1);
    chk("start", 32'(n >= 20 && n <= 30), 32'h1);
    chk("exp_oe", goe[2], 1'b1);
    chk("exp_l", exp_l, 1'b1);
    wb(1'b1, 8'h24, 32'h1);
    wt(4);
    chk("cmd_kick", gout[2], 1'b0);
    wb(1'b0, 8'h28, 32'h0);
    chk("latched", q[1:0], 2'b10);
    chk("lat_l", lat_l, 1'b1);
    wb(1'b1, 8'h24, 32'h2);
    chk("lat_clr", lat_l, 1'b0);
    wb(1'b0, 8'h28, 32'h0);
    chk("cleared", q[1], 1'b0);
    repeat (4) begin
      kick();
      wt(5);
      chk("kept", gout[2], 1'b0);
    end
    wait_pin(2, 1'b1);
    chk("period", 32'(n >= 12 && n <= 20), 32'h1);
    wb(1'b1, 8'h00, 32'h4);
  endtask : t_wdog
  task automatic t_rst();
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b1, 8'h1C, 32'h8);
    wb(1'b1, 8'h10, 32'h2);
    pg_on[0] <= 1'b1;
    wt(6);
    chk("gpi_low", gout[0], 1'b0);
    gin[3] <= 1'b1;
    wait_pin(0, 1'b1);
    chk("delay", 32'(n >= 9 && n <= 14), 32'h1);
    pg_bad[0] <= 1'b1;
    wt(3);
    chk("drop", gout[0], 1'b0);
    pg_bad[0] <= 1'b0;
    wait_pin(0, 1'b1);
    wb(1'b1, 8'h14, 32'h2);
    wt(1);
    chk("reconf", gout[0], 1'b0);
    wb(1'b1, 8'h00, 32'hC);
    wt(30);
    gin[3] <= 1'b0;
    wt(5);
    chk("pulse_hold", gout[0], 1'b1);
    gin[3] <= 1'b1;
    wait_pin(0, 1'b0);
    wait_pin(0, 1'b1);
    chk("width", 32'(n >= 8 && n <= 10), 32'h1);
  endtask : t_rst
  // Hold-off, pulsed expiry pin, expiry merged into a pulsed reset, clear by pin
  task automatic t_merge();
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h00, 32'h1F);
    wt(390);
    wait_pin(2, 1'b1);
    chk("hold", 32'(n >= 18 && n <= 26), 32'h1);
    chk("merge_rst", gout[0], 1'b0);
    chk("exp_l2", exp_l, 1'b1);
    wait_pin(2, 1'b0);
    chk("exp_pulse", 32'(n >= 3 && n <= 5), 32'h1);
    wait_pin(0, 1'b1);
    chk("merge_w", 32'(n >= 3 && n <= 7), 32'h1);
    chk("lat_set", lat_l, 1'b1);
    wb(1'b1, 8'h20, 32'h24202221);
    gin[4] <= 1'b1;
    wt(5);
    chk("lat_pin", lat_l, 1'b0);
    gin[4] <= 1'b0;
  endtask : t_merge
  // Main sequence
  initial begin
    {nrst, cyc, stb, we, kick_go} = 5'h00;
    {adr, dat, gin, pg_on, pg_bad} = '0;
    failures = 0;
    n_tests = 0;
    wt(3);
    chk("rst_pin", {goe[0], gout[0]}, 2'b10);
    nrst <= 1'b1;
    wt(10);
    chk("release", gout[0], 1'b1);
    t_regs();
    t_wdog();
    t_rst();
    t_merge();
    conclude();
  end
  // Hang guard
  initial begin
    #30000;
    failures++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
